// *** adcc_map.svh ***
// Purpose: Constants for the converter control block
// Assumes: 10 MHz mclk_i, synchronous active-low reset
// Notes:   Functional notes follow
//
// Functional notes
// (R1) Sixteen pin inputs plus bandgap code
// (R2) Unimplemented codes sample low reference
// (R3) Reserved codes undefined; 11101 samples high reference
// (R4) Software enables bandgap buffer before bandgap
// (R5) Each pin input has own enable bit
// (R6) Four conversion clock sources selectable
// (R7) Alternate clock needs external clock mode
// (R8) Selected clock passes programmable divider
// (R9) Alternate clock usable in wait, not partial_power_down_mode
// (R10) Counter overflow starts conversion when enabled
// (R11) Counter clocked by 1 kHz or reference
// (R12) Only two pin enable registers exist
// (R13) Software sets both low-voltage bits first
// (R14) Ten-bit linear successive approximation
// (R15) Result right-justified, 10 or 8 bits
// (R16) Single and continuous modes, auto idle
// (R17) Compare less-than or greater-or-equal
// (R18) Sample time and speed configurable
// (R19) All-ones select powers converter off
// (R20) Control write aborts and restarts conversion
// (R21) Done flag cleared by write or read
// (R22) With compare, flag only if true
// (R23) Two-bit clock source field
`ifndef ADCC_MAP_SVH
`define ADCC_MAP_SVH
`define ADCC_SEL_W        5
`define ADCC_RES_W        10
`define ADCC_PIN_LAST     5'h0F
`define ADCC_VREFL_FIRST  5'h10
`define ADCC_VREFL_LAST   5'h15
`define ADCC_CODE_BANDGAP 5'h1B
`define ADCC_CODE_VREFH   5'h1D
`define ADCC_CODE_VREFL   5'h1E
`define ADCC_CODE_OFF     5'h1F
`define ADCC_CLK_BUS      2'h0
`define ADCC_CLK_BUS_DIV2 2'h1
`define ADCC_CLK_ALT      2'h2
`define ADCC_CLK_ASYNC    2'h3
`define ADCC_SHORT_SAMPLE 4'h3
`define ADCC_LONG_SAMPLE  4'hF
`define ADCC_SETTLE       2'h2
`endif

// *** adcc_pkg.sv ***
// Purpose: Types for the converter control block
// Assumes: Constants come from adcc_map.svh
// Notes:   None
package adcc_pkg;
	typedef enum logic [2:0] {ADCC_OFF, ADCC_IDLE, ADCC_SAMPLE, ADCC_CONVERT, ADCC_DONE} adcc_state_t;
	typedef enum logic [2:0] {ADCC_IN_PIN, ADCC_IN_VREFL, ADCC_IN_VREFH, ADCC_IN_BANDGAP,
		ADCC_IN_RESERVED, ADCC_IN_NONE} adcc_input_t;
endpackage

// *** adcc_clkgen.sv ***
// Purpose: Conversion clock enable from the chosen source and divider
// Assumes: Clock sources arrive as pins; they are synchronised here
// Notes:   Produces one-cycle tick per conversion clock edge
`timescale 1ns/100ps
`include "adcc_map.svh"
module adcc_clkgen
	import adcc_pkg::*;
(
	// Clock and reset
	input  wire logic       mclk_i,
	input  wire logic       reset_n_i,
	input  wire logic       ce_i,
	// Source selection
	input  wire logic [1:0] clk_src_i,
	input  wire logic [1:0] clock_divide_field_i,
	input  wire logic       async_clk_i,
	input  wire logic       alt_clk_i,
	input  wire logic       alt_ok_i,
	// Tick
	output logic            tick_o
);
	logic [1:0] async_sync_ff;
	logic [1:0] alt_sync_ff;
	logic       async_last_ff;
	logic       alt_last_ff;
	logic       half_ff;
	logic [2:0] div_cnt_ff;
	logic       src_tick;
	logic [2:0] div_last;

	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			async_sync_ff <= 2'h0;
			alt_sync_ff   <= 2'h0;
			async_last_ff <= 1'b0;
			alt_last_ff   <= 1'b0;
		end else if (ce_i) begin
			async_sync_ff <= {async_sync_ff[0], async_clk_i};
			alt_sync_ff   <= {alt_sync_ff[0], alt_clk_i};
			async_last_ff <= async_sync_ff[1];
			alt_last_ff   <= alt_sync_ff[1];
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!reset_n_i)
			half_ff <= 1'b0;
		else if (ce_i)
			half_ff <= ~half_ff;
	end

	// Source multiplexer
	always_comb begin
		case (clk_src_i) // R6 R23
			`ADCC_CLK_BUS:      src_tick = 1'b1;
			`ADCC_CLK_BUS_DIV2: src_tick = half_ff;
			`ADCC_CLK_ALT:      src_tick = alt_ok_i & alt_sync_ff[1] & ~alt_last_ff; // R9
			default:            src_tick = async_sync_ff[1] & ~async_last_ff;
		endcase
	end

	// Divide by 1, 2, 4 or 8
	assign div_last = 3'((4'h1 << clock_divide_field_i) - 4'h1);

	always_ff @(posedge mclk_i) begin
		if (!reset_n_i)
			div_cnt_ff <= 3'h0;
		else if (ce_i && src_tick)
			div_cnt_ff <= (div_cnt_ff >= div_last) ? 3'h0 : div_cnt_ff + 3'h1; // R8
	end

	assign tick_o = ce_i & src_tick & (div_cnt_ff >= div_last); // R8
endmodule

// *** adcc_ctrl.sv ***
// Purpose: Converter control: input decode, sequencing, compare, flag
// Assumes: Comparator output from analog side is synchronised here
// Notes:   Software bits are plain ports; writes and reads are strobes
`timescale 1ns/100ps
`include "adcc_map.svh"
module adcc_ctrl
	import adcc_pkg::*;
(
	// Clock and reset
	input  wire logic                    mclk_i,
	input  wire logic                    reset_n_i,
	input  wire logic                    ce_i,
	// Control strobes and fields
	input  wire logic                    ctrl_write_i,
	input  wire logic [`ADCC_SEL_W-1:0]  input_select_code_i,
	input  wire logic                    continuous_i,
	input  wire logic                    result_low_read_i,
	input  wire logic                    hw_trigger_enable_i,
	input  wire logic                    compare_function_enable_i,
	input  wire logic                    compare_greater_i,
	input  wire logic [`ADCC_RES_W-1:0]  compare_value_i,
	input  wire logic                    mode_8bit_i,
	input  wire logic                    long_sample_i,
	input  wire logic                    low_power_i,
	// Pin enables
	input  wire logic [7:0]              pin_enable_reg_low_i,
	input  wire logic [7:0]              pin_enable_reg_high_i,
	// Clocking
	input  wire logic [1:0]              clk_src_i,
	input  wire logic [1:0]              clock_divide_field_i,
	input  wire logic                    local_async_conv_clock_i,
	input  wire logic                    alternate_conv_clock_i,
	input  wire logic                    partial_power_down_mode_i,
	// Periodic trigger
	input  wire logic                    periodic_rate_src_ref_i,
	input  wire logic                    slow_clk_i,
	input  wire logic                    ext_reference_clock_i,
	input  wire logic [3:0]              periodic_rate_select_i,
	// Analog side
	input  wire logic                    comparator_i,
	output logic [`ADCC_SEL_W-1:0]       analog_mux_sel_o,
	output adcc_input_t                  input_kind_o,
	output logic [15:0]                  pin_analog_enable_bit_o,
	output logic                         converter_power_o,
	output logic                         sample_o,
	output logic [`ADCC_RES_W-1:0]       dac_code_o,
	// Status
	output logic [`ADCC_RES_W-1:0]       result_o,
	output logic                         conversion_done_flag_o,
	output logic                         busy_o
);
	adcc_state_t               state_ff;
	logic [1:0]                cmp_sync_ff;
	logic [3:0]                samp_cnt_ff;
	logic [3:0]                bit_ff;
	logic [`ADCC_RES_W-1:0]    sar_ff;
	logic [`ADCC_RES_W-1:0]    result_ff;
	logic                      done_ff;
	logic [1:0]                slow_sync_ff;
	logic [1:0]                ref_sync_ff;
	logic                      rate_last_ff;
	logic [15:0]               rate_cnt_ff;
	logic                      tick;
	logic                      rate_edge;
	logic                      hw_trig;
	logic                      disabled;
	logic                      start;
	logic                      cmp_true;
	logic [`ADCC_RES_W-1:0]    fmt;
	logic [1:0]                settle_ff;
	logic                      conv_step;

	function automatic adcc_input_t decode_kind(input logic [`ADCC_SEL_W-1:0] c);
		if (c <= `ADCC_PIN_LAST)
			decode_kind = ADCC_IN_PIN; // R1
		else if ((c >= `ADCC_VREFL_FIRST && c <= `ADCC_VREFL_LAST) || c == `ADCC_CODE_VREFL)
			decode_kind = ADCC_IN_VREFL; // R2
		else if (c == `ADCC_CODE_VREFH)
			decode_kind = ADCC_IN_VREFH; // R3
		else if (c == `ADCC_CODE_BANDGAP)
			decode_kind = ADCC_IN_BANDGAP; // R1 R4
		else if (c == `ADCC_CODE_OFF)
			decode_kind = ADCC_IN_NONE; // R19
		else
			decode_kind = ADCC_IN_RESERVED; // R3
	endfunction

	// Sample length in conversion clock ticks
	function automatic logic [3:0] sample_len(input logic long_sel);
		sample_len = long_sel ? `ADCC_LONG_SAMPLE : `ADCC_SHORT_SAMPLE; // R18
	endfunction

	adcc_clkgen u_clkgen (
		.mclk_i               (mclk_i),
		.reset_n_i            (reset_n_i),
		.ce_i                 (ce_i),
		.clk_src_i            (clk_src_i),
		.clock_divide_field_i (clock_divide_field_i),
		.async_clk_i          (local_async_conv_clock_i),
		.alt_clk_i            (alternate_conv_clock_i),
		.alt_ok_i             (~partial_power_down_mode_i),
		.tick_o               (tick)
	);

	assign disabled = (input_select_code_i == `ADCC_CODE_OFF); // R19

	// Periodic counter; R11: reference unusable in partial_power_down_mode
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			slow_sync_ff <= 2'h0;
			ref_sync_ff  <= 2'h0;
			rate_last_ff <= 1'b0;
		end else if (ce_i) begin
			slow_sync_ff <= {slow_sync_ff[0], slow_clk_i};
			ref_sync_ff  <= {ref_sync_ff[0], ext_reference_clock_i};
			rate_last_ff <= periodic_rate_src_ref_i ? ref_sync_ff[1] : slow_sync_ff[1];
		end
	end

	assign rate_edge = (periodic_rate_src_ref_i ? (ref_sync_ff[1] & ~partial_power_down_mode_i)
		: slow_sync_ff[1]) & ~rate_last_ff; // R11

	always_ff @(posedge mclk_i) begin
		if (!reset_n_i)
			rate_cnt_ff <= 16'h0000;
		else if (ce_i && rate_edge)
			rate_cnt_ff <= hw_trig ? 16'h0000 : rate_cnt_ff + 16'h0001;
	end

	assign hw_trig = rate_edge && (rate_cnt_ff >= 16'((17'h1 << periodic_rate_select_i) - 17'h1)); // R10

	assign start = (ctrl_write_i && !disabled) || // R20
		(hw_trigger_enable_i && hw_trig && !disabled && state_ff == ADCC_IDLE); // R10

	// One bit decision; only once the new trial code has crossed the synchroniser
	assign conv_step = tick && !disabled && !start && state_ff == ADCC_CONVERT &&
		settle_ff == 2'h0; // R14

	// Settling count: a trial code needs two edges to reach cmp_sync_ff[1]
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i)
			settle_ff <= 2'h0;
		else if (ce_i) begin
			if (conv_step)
				settle_ff <= `ADCC_SETTLE; // R14
			else if (settle_ff != 2'h0)
				settle_ff <= settle_ff - 2'h1;
		end
	end

	// Sequencer
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			state_ff    <= ADCC_OFF;
			samp_cnt_ff <= 4'h0;
			bit_ff      <= 4'h0;
			sar_ff      <= 10'h000;
			cmp_sync_ff <= 2'h0;
		end else if (ce_i) begin
			cmp_sync_ff <= {cmp_sync_ff[0], comparator_i};
			if (disabled)
				state_ff <= ADCC_OFF; // R19
			else if (start) begin
				state_ff    <= ADCC_SAMPLE; // R20
				samp_cnt_ff <= sample_len(long_sample_i); // R18
				sar_ff      <= 10'h200;
				bit_ff      <= 4'h9;
			end else if (tick) begin
				case (state_ff)
					ADCC_SAMPLE: begin
						if (samp_cnt_ff == 4'h0)
							state_ff <= ADCC_CONVERT;
						else
							samp_cnt_ff <= samp_cnt_ff - 4'h1;
					end
					ADCC_CONVERT: begin // R14
						if (settle_ff == 2'h0) begin
							sar_ff[bit_ff] <= cmp_sync_ff[1];
							if (bit_ff == 4'h0)
								state_ff <= ADCC_DONE;
							else begin
								sar_ff[bit_ff - 4'h1] <= 1'b1;
								bit_ff <= bit_ff - 4'h1;
							end
						end
					end
					ADCC_DONE: begin
						if (continuous_i) begin
							state_ff    <= ADCC_SAMPLE; // R16
							samp_cnt_ff <= sample_len(long_sample_i);
							sar_ff      <= 10'h200;
							bit_ff      <= 4'h9;
						end else
							state_ff <= ADCC_IDLE; // R16
					end
					ADCC_OFF: state_ff <= ADCC_IDLE;
					default:  state_ff <= state_ff;
				endcase
			end
		end
	end

	assign fmt = mode_8bit_i ? {2'h0, sar_ff[9:2]} : sar_ff; // R15
	assign cmp_true = compare_greater_i ? (fmt >= compare_value_i) : (fmt < compare_value_i); // R17

	// Result and done flag
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			result_ff <= 10'h000;
			done_ff   <= 1'b0;
		end else if (ce_i) begin
			if (state_ff == ADCC_DONE && tick && !start &&
				(!compare_function_enable_i || cmp_true)) begin // R22
				result_ff <= fmt;
				done_ff   <= 1'b1;
			end else if (ctrl_write_i || result_low_read_i)
				done_ff <= 1'b0; // R21
		end
	end

	// Pin enables: two registers only
	assign pin_analog_enable_bit_o = {pin_enable_reg_high_i, pin_enable_reg_low_i}; // R5 R12
	assign analog_mux_sel_o        = input_select_code_i;
	assign input_kind_o            = decode_kind(input_select_code_i);
	assign converter_power_o       = !disabled && (state_ff != ADCC_IDLE || !low_power_i); // R18 R19
	assign sample_o                = (state_ff == ADCC_SAMPLE);
	assign dac_code_o              = sar_ff;
	assign result_o                = result_ff;
	assign conversion_done_flag_o  = done_ff;
	assign busy_o                  = (state_ff == ADCC_SAMPLE || state_ff == ADCC_CONVERT);
endmodule

// *** adcc_ctrl_properties.sv ***
// Purpose: Port assertions for adcc_ctrl
// Assumes: Bound into adcc_ctrl; one clock domain
// Notes:   Decode checks look at the cycle of a start, except off_decode_a, which checks every cycle
`timescale 1ns/100ps
module adcc_ctrl_chk
	import adcc_pkg::*;
(
	// Inputs of the block
	input wire logic         mclk_i,
	input wire logic         reset_n_i,
	input wire logic         ce_i,
	input wire logic         ctrl_write_i,
	input wire logic [4:0]   input_select_code_i,
	input wire logic         result_low_read_i,
	input wire logic         compare_function_enable_i,
	input wire logic         compare_greater_i,
	input wire logic [9:0]   compare_value_i,
	input wire logic         mode_8bit_i,
	input wire logic [7:0]   pin_enable_reg_low_i,
	input wire logic [7:0]   pin_enable_reg_high_i,
	// Outputs of the block
	input wire adcc_input_t  input_kind_o,
	input wire logic [15:0]  pin_analog_enable_bit_o,
	input wire logic         converter_power_o,
	input wire logic [9:0]   result_o,
	input wire logic         conversion_done_flag_o,
	input wire logic         busy_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	sequence start_s;
		ctrl_write_i && ce_i && input_select_code_i != 5'h1F;
	endsequence
	sequence done_s;
		$rose(conversion_done_flag_o);
	endsequence
	start_busy_a: assert property (start_s |=> busy_o)
		else $error("busy missing after start");
	write_clear_a: assert property (ctrl_write_i && ce_i |=> !conversion_done_flag_o)
		else $error("flag kept after write");
	read_clear_a: assert property (result_low_read_i && ce_i && !busy_o |=> !conversion_done_flag_o)
		else $error("flag kept after read");
	off_quiet_a: assert property ((input_select_code_i == 5'h1F) [*3] |-> !converter_power_o && !busy_o)
		else $error("converter active while off");
	pin_decode_a: assert property (start_s ##0 input_select_code_i <= 5'h0F |-> input_kind_o == ADCC_IN_PIN)
		else $error("pin code decoded wrongly");
	vrefl_decode_a: assert property (start_s ##0 input_select_code_i inside {[5'h10:5'h15], 5'h1E}
		|-> input_kind_o == ADCC_IN_VREFL) else $error("low reference code decoded wrongly");
	vrefh_decode_a: assert property (start_s ##0 input_select_code_i == 5'h1D |-> input_kind_o == ADCC_IN_VREFH)
		else $error("high reference code decoded wrongly");
	bandgap_decode_a: assert property (start_s ##0 input_select_code_i == 5'h1B
		|-> input_kind_o == ADCC_IN_BANDGAP) else $error("bandgap code decoded wrongly");
	reserved_decode_a: assert property (start_s ##0 input_select_code_i inside {[5'h16:5'h1A], 5'h1C}
		|-> input_kind_o == ADCC_IN_RESERVED) else $error("reserved code decoded wrongly");
	off_decode_a: assert property (input_select_code_i == 5'h1F |-> input_kind_o == ADCC_IN_NONE)
		else $error("off code decoded wrongly");
	pin_enable_a: assert property ($stable({pin_enable_reg_high_i, pin_enable_reg_low_i})
		|-> pin_analog_enable_bit_o == {pin_enable_reg_high_i, pin_enable_reg_low_i}) else $error("pin enables");
	compare_gate_a: assert property (done_s ##0 compare_function_enable_i && !mode_8bit_i
		|-> (compare_greater_i ? result_o >= compare_value_i : result_o < compare_value_i)) else $error("flag on false compare");
	eight_bit_a: assert property (done_s ##0 mode_8bit_i |-> result_o[9:8] == 2'h0)
		else $error("8-bit result not right-justified");
endmodule
bind adcc_ctrl adcc_ctrl_chk i_adcc_ctrl_chk (.*);

// *** adcc_analog_model.sv ***
// Purpose: Analog side of the converter as a comparator model
// Assumes: Comparator high when the input is at or above the trial code
// Notes:   Unpowered or unconnected inputs give a toggling comparator
`timescale 1ns/100ps
module adcc_analog_model #(
	parameter logic [9:0] BANDGAP_LEVEL = 10'h1A0
)
(
	// Converter side
	input  wire logic        mclk_i,
	input  wire logic [4:0]  analog_mux_sel_i,
	input  wire logic [15:0] pin_analog_enable_bit_i,
	input  wire logic        converter_power_i,
	input  wire logic [9:0]  dac_code_i,
	input  wire logic        bandgap_buffer_enable_i,
	// Comparator
	output logic             comparator_o
);
	logic [9:0] level;
	logic       valid;
	logic       noise_ff = 1'h0;
	always_ff @(posedge mclk_i) begin
		noise_ff <= !noise_ff;
	end
	always_comb begin
		level = 10'h000;
		valid = converter_power_i;
		if (analog_mux_sel_i <= 5'h0F) begin
			level = {analog_mux_sel_i[3:0], 6'h25};
			valid = valid && pin_analog_enable_bit_i[analog_mux_sel_i[3:0]];
		end else if (analog_mux_sel_i == 5'h1B) begin
			level = BANDGAP_LEVEL;
			valid = valid && bandgap_buffer_enable_i;
		end else if (analog_mux_sel_i == 5'h1D)
			level = 10'h3FF;
		else if (!(analog_mux_sel_i inside {[5'h10:5'h15], 5'h1E}))
			valid = 1'h0;
		comparator_o = valid ? (level >= dac_code_i) : noise_ff;
	end
endmodule

// *** adcc_ctrl_bench.sv ***
// Purpose: Self-checking bench for adcc_ctrl
// Assumes: Pin n sits at level {n, 6'h25}
// Notes:   Slow clocks are shortened to keep the run brief
`timescale 1ns/100ps
module adcc_ctrl_bench import adcc_pkg::*;;
	localparam logic [9:0] BG = 10'h1A0;
	logic mclk_i = 1'h0, reset_n_i = 1'h0, ce_i = 1'h1, ctrl_write_i = 1'h0, continuous_i = 1'h0;
	logic result_low_read_i = 1'h0, hw_trigger_enable_i = 1'h0, compare_function_enable_i = 1'h0;
	logic compare_greater_i = 1'h0, mode_8bit_i = 1'h0, long_sample_i = 1'h0, low_power_i = 1'h0;
	logic partial_power_down_mode_i = 1'h0, periodic_rate_src_ref_i = 1'h0, slow_clk_i = 1'h0;
	logic local_async_conv_clock_i = 1'h0, alternate_conv_clock_i = 1'h0, bandgap_buffer_enable = 1'h0;
	logic [4:0] input_select_code_i = 5'h00, analog_mux_sel_o;
	logic [9:0] compare_value_i = 10'h000, dac_code_o, result_o;
	logic [7:0] pin_enable_reg_low_i = 8'hFF, pin_enable_reg_high_i = 8'hFF;
	logic [1:0] clk_src_i = 2'h0, clock_divide_field_i = 2'h2;
	logic [3:0] periodic_rate_select_i = 4'h2;
	logic [15:0] pin_analog_enable_bit_o;
	logic comparator_i, converter_power_o, conversion_done_flag_o, busy_o, sample_o;
	adcc_input_t input_kind_o;
	int bad_count = 0, compares = 0;
	always #50 mclk_i = !mclk_i;
	always #150 local_async_conv_clock_i = !local_async_conv_clock_i;
	always #200 alternate_conv_clock_i = !alternate_conv_clock_i;
	always #350 slow_clk_i = !slow_clk_i;
	adcc_ctrl i_adcc_ctrl (.*, .ext_reference_clock_i(alternate_conv_clock_i), .input_kind_o(input_kind_o),
		.sample_o(sample_o));
	adcc_analog_model #(.BANDGAP_LEVEL(BG)) i_adcc_analog_model (.mclk_i, .analog_mux_sel_i(analog_mux_sel_o),
		.pin_analog_enable_bit_i(pin_analog_enable_bit_o), .converter_power_i(converter_power_o),
		.dac_code_i(dac_code_o), .bandgap_buffer_enable_i(bandgap_buffer_enable), .comparator_o(comparator_i));
	task cyc(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task start(input logic [4:0] code);
		input_select_code_i = code;
		ctrl_write_i = 1'h1;
		cyc(1);
		ctrl_write_i = 1'h0;
	endtask
	task wait_done(input int lim);
		for (int i = 0; i < lim && conversion_done_flag_o !== 1'h1; i++) cyc(1);
	endtask
	task clear_flag;
		result_low_read_i = 1'h1;
		cyc(1);
		result_low_read_i = 1'h0;
	endtask
	function logic [9:0] lvl(input logic [4:0] c);
		return c <= 5'h0F ? {c[3:0], 6'h25} : c == 5'h1D ? 10'h3FF : c == 5'h1B ? BG : 10'h000;
	endfunction
	task conv(input logic [4:0] code);
		start(code);
		wait_done(3000);
		chk({conversion_done_flag_o, result_o}, {1'h1, mode_8bit_i ? lvl(code) >> 2 : lvl(code)});
		clear_flag;
		chk(conversion_done_flag_o, 1'h0);
	endtask
	task t_inputs;
		bandgap_buffer_enable = 1'h1;
		for (int c = 0; c < 32; c++)
			if (c <= 'h15 || c == 'h1B || c == 'h1D || c == 'h1E) conv(c[4:0]);
		start(5'h16);
		chk(input_kind_o, ADCC_IN_RESERVED);
		cyc(1);
		start(5'h1C);
		chk(input_kind_o, ADCC_IN_RESERVED);
		cyc(1);
		mode_8bit_i = 1'h1;
		conv(5'h0C);
		mode_8bit_i = 1'h0;
	endtask
	task t_abort;
		start(5'h02);
		chk({busy_o, sample_o, dac_code_o}, {2'h3, 10'h200});
		ce_i = 1'h0;
		cyc(100);
		chk({busy_o, sample_o, conversion_done_flag_o}, 3'h6);
		ce_i = 1'h1;
		cyc(20);
		conv(5'h07);
		cyc(20);
		chk({busy_o, converter_power_o}, 2'h1);
	endtask
	task t_compare;
		compare_function_enable_i = 1'h1;
		for (int k = 0; k < 4; k++) begin
			compare_greater_i = k[1];
			compare_value_i = 10'h0E5 + k[0];
			start(5'h03);
			wait_done(600);
			chk(conversion_done_flag_o, k[1] ^ k[0]);
			clear_flag;
		end
		compare_function_enable_i = 1'h0;
	endtask
	task t_clocks;
		for (int s = 0; s < 4; s++) begin
			clk_src_i = s[1:0];
			clock_divide_field_i = s[1:0];
			long_sample_i = s[0];
			low_power_i = s[1];
			conv(5'h0A);
		end
		clk_src_i = 2'h2;
		partial_power_down_mode_i = 1'h1;
		start(5'h0A);
		wait_done(1500);
		chk(conversion_done_flag_o, 1'h0);
		partial_power_down_mode_i = 1'h0;
		conv(5'h0A);
		chk(converter_power_o, 1'h0);
		clk_src_i = 2'h0;
		clock_divide_field_i = 2'h2;
	endtask
	task t_hw;
		input_select_code_i = 5'h05;
		hw_trigger_enable_i = 1'h1;
		wait_done(500);
		chk({conversion_done_flag_o, result_o}, {1'h1, lvl(5'h05)});
		hw_trigger_enable_i = 1'h0;
		cyc(200);
		clear_flag;
		cyc(300);
		chk(conversion_done_flag_o, 1'h0);
		periodic_rate_src_ref_i = 1'h1;
		partial_power_down_mode_i = 1'h1;
		input_select_code_i = 5'h06;
		hw_trigger_enable_i = 1'h1;
		wait_done(300);
		chk(conversion_done_flag_o, 1'h0);
		partial_power_down_mode_i = 1'h0;
		wait_done(300);
		chk({conversion_done_flag_o, result_o}, {1'h1, lvl(5'h06)});
		hw_trigger_enable_i = 1'h0;
		periodic_rate_src_ref_i = 1'h0;
		cyc(200);
		clear_flag;
	endtask
	task t_cont;
		continuous_i = 1'h1;
		conv(5'h09);
		wait_done(500);
		chk({conversion_done_flag_o, result_o}, {1'h1, lvl(5'h09)});
		start(5'h1F);
		cyc(3);
		chk({busy_o, converter_power_o}, 2'h0);
		clear_flag;
		cyc(300);
		chk(conversion_done_flag_o, 1'h0);
		continuous_i = 1'h0;
	endtask
	task stop_test;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		cyc(20);
		reset_n_i = 1'h1;
		chk({conversion_done_flag_o, result_o}, 11'h000);
		cyc(2);
		t_inputs;
		t_abort;
		t_compare;
		t_clocks;
		t_hw;
		t_cont;
		stop_test;
	end
	initial begin
		repeat (40000) @(posedge mclk_i);
		bad_count++;
		stop_test;
	end
endmodule
